// ==== core/ccr_regs.sv ====
`timescale 1ns/1ps
`include "ccr_map.svh"

// What this block does
// - Bit 2 of clock control one, reset 0, selects PECL input mode for the main device clock.
// - Bit 1 of clock control one, reset 0, selects PECL input mode for the alignment reference input.
// - Bit 0 of clock control one, reset 0, makes the alignment logic use the inverted reference signal.
// - Bit 2 of clock control two, reset 0, enables noise quieting on the analog core rail.
// - Bit 0 of clock control two, reset 0, enables noise quieting on the clock rail.
// - The capture position register reads back a 24-bit status of the reference edge against the clock.
// - The full scale range register is 16 bits read/write, reset 0xa000, for all channels at once.
// - The power mode register resets to high performance 0x4b and 0x46 selects low power, others reserved.
// - Bits 3:0 of clock control zero, reset 0, choose the reference sampling delay.

module ccr_regs
	import ccr_pkg::*;
#(
	parameter int POS_WIDTH = 24
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Serial control port
	input  wire logic        spiSclk,
	input  wire logic        spiCsN,
	input  wire logic        spiSdi,
	output wire logic        spiSdo,
	output wire logic        spiSdoOe,
	// Alignment reference and its position detector
	input  wire logic        sysrefIn,
	input  wire logic [23:0] sysrefPosition,
	output wire logic        sysrefAligned,
	// Stored settings
	output wire logic        mainClockPeclInputMode,
	output wire logic        sysrefPeclInputMode,
	output wire logic        sysrefPolarityInvert,
	output wire logic        analogRailQuietingEnable,
	output wire logic        clockRailQuietingEnable,
	output wire logic [3:0]  sysrefDelaySelect,
	output wire logic [15:0] fullScaleRange,
	output wire logic [7:0]  powerModeCode,
	output wire logic        lowPowerMode
);

	generate
		if (POS_WIDTH != 24)
		begin : g_badWidth
			$error("ccr_regs: POS_WIDTH must be 24");
		end
	endgenerate

	logic [1:0]     rstSync_q;
	logic           rstnSync;
	ccr_reg_state_t r_q;
	ccr_reg_state_t r_d;
	logic [14:0]    rdAddr;
	logic [7:0]     rdData;
	logic           wrStb;
	logic [14:0]    wrAddr;
	logic [7:0]     wrData;

	// Reset release through two flops
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rstSync_q <= 2'h0;
		else
			rstSync_q <= {rstSync_q[0], 1'b1};
	end
	assign rstnSync = rstSync_q[1];

	ccr_spi_port u_spi (
		.clk      (clk),
		.rstnSync (rstnSync),
		.spiSclk  (spiSclk),
		.spiCsN   (spiCsN),
		.spiSdi   (spiSdi),
		.spiSdo   (spiSdo),
		.spiSdoOe (spiSdoOe),
		.rdAddr   (rdAddr),
		.rdData   (rdData),
		.wrStb    (wrStb),
		.wrAddr   (wrAddr),
		.wrData   (wrData)
	);

	always_comb
	begin
		r_d     = r_q;
		r_d.pos = sysrefPosition;
		// Inversion applied before the alignment logic sees the edge
		r_d.sysrefOut = sysrefIn ^ r_q.clk1[`CCR_BIT_SREF_INV];
		if (wrStb)
		begin
			case (wrAddr)
				`CCR_ADDR_CLK0: r_d.clk0 = wrData;
				`CCR_ADDR_CLK1: r_d.clk1 = wrData;
				`CCR_ADDR_CLK2: r_d.clk2 = wrData;
				`CCR_ADDR_FSR0: r_d.fsr[7:0] = wrData;
				`CCR_ADDR_FSR1: r_d.fsr[15:8] = wrData;
				`CCR_ADDR_PWR1:
				begin
					// Reserved codes are dropped so the mode stays a legal one
					if (wrData == `CCR_PWR_LOW || wrData == `CCR_PWR_HIGH)
						r_d.pwr = wrData;
				end
				default:
				begin
					// Capture position and unmapped addresses take no write
					r_d.pwr = r_q.pwr;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstnSync)
	begin
		if (!rstnSync)
		begin
			r_q.clk0      <= `CCR_RST_CLK0;
			r_q.clk1      <= `CCR_RST_CLK1;
			r_q.clk2      <= `CCR_RST_CLK2;
			r_q.pos       <= `CCR_RST_POS;
			r_q.fsr       <= `CCR_RST_FSR;
			r_q.pwr       <= `CCR_RST_PWR1;
			r_q.sysrefOut <= 1'b0;
		end
		else
			r_q <= r_d;
	end

	// Read mux; unmapped addresses read as zero
	always_comb
	begin
		case (rdAddr)
			`CCR_ADDR_CLK0: rdData = r_q.clk0;
			`CCR_ADDR_CLK1: rdData = r_q.clk1;
			`CCR_ADDR_CLK2: rdData = r_q.clk2;
			`CCR_ADDR_POS0: rdData = r_q.pos[7:0];
			`CCR_ADDR_POS1: rdData = r_q.pos[15:8];
			`CCR_ADDR_POS2: rdData = r_q.pos[23:16];
			`CCR_ADDR_FSR0: rdData = r_q.fsr[7:0];
			`CCR_ADDR_FSR1: rdData = r_q.fsr[15:8];
			`CCR_ADDR_PWR1: rdData = r_q.pwr;
			default: rdData = 8'h00;
		endcase
	end

	assign mainClockPeclInputMode   = r_q.clk1[`CCR_BIT_MAIN_PECL];
	assign sysrefPeclInputMode      = r_q.clk1[`CCR_BIT_SREF_PECL];
	assign sysrefPolarityInvert     = r_q.clk1[`CCR_BIT_SREF_INV];
	assign analogRailQuietingEnable = r_q.clk2[`CCR_BIT_ANA_QUIET];
	assign clockRailQuietingEnable  = r_q.clk2[`CCR_BIT_CLK_QUIET];
	assign sysrefDelaySelect        = r_q.clk0[`CCR_DLY_MSB:`CCR_DLY_LSB];
	assign fullScaleRange           = r_q.fsr;
	assign powerModeCode            = r_q.pwr;
	assign lowPowerMode             = (r_q.pwr == `CCR_PWR_LOW);
	assign sysrefAligned            = r_q.sysrefOut;

	sequence s_wr(logic [14:0] a);
		wrStb && (wrAddr == a);
	endsequence

	sequence s_posWr;
		wrStb && (wrAddr == `CCR_ADDR_POS0 || wrAddr == `CCR_ADDR_POS1 || wrAddr == `CCR_ADDR_POS2);
	endsequence

	a_main_pecl: assert property (@(posedge clk) disable iff (!rstnSync)
		s_wr(`CCR_ADDR_CLK1) |=> mainClockPeclInputMode == $past(wrData[2]))
		else $error("main clock pecl mode did not follow write");

	a_sref_pecl: assert property (@(posedge clk) disable iff (!rstnSync)
		s_wr(`CCR_ADDR_CLK1) |=> sysrefPeclInputMode == $past(wrData[1]))
		else $error("reference pecl mode did not follow write");

	a_sref_invert: assert property (@(posedge clk) disable iff (!rstnSync)
		##1 sysrefAligned == ($past(sysrefIn) ^ $past(sysrefPolarityInvert)))
		else $error("aligned reference has wrong polarity");

	a_ana_quiet: assert property (@(posedge clk) disable iff (!rstnSync)
		s_wr(`CCR_ADDR_CLK2) |=> analogRailQuietingEnable == $past(wrData[2]) ##1 $stable(analogRailQuietingEnable)
			or s_wr(`CCR_ADDR_CLK2))
		else $error("analog rail quieting wrong after write");

	a_clk_quiet: assert property (@(posedge clk) disable iff (!rstnSync)
		s_wr(`CCR_ADDR_CLK2) |=> clockRailQuietingEnable == $past(wrData[0]))
		else $error("clock rail quieting wrong after write");

	a_pos_read: assert property (@(posedge clk) disable iff (!rstnSync)
		rdAddr == `CCR_ADDR_POS2 |-> ##1 rdAddr != `CCR_ADDR_POS2 || rdData == $past(sysrefPosition[23:16]))
		else $error("capture position readback mismatch");

	a_fsr_write: assert property (@(posedge clk) disable iff (!rstnSync)
		s_wr(`CCR_ADDR_FSR1) |=> fullScaleRange[15:8] == $past(wrData) && $stable(fullScaleRange[7:0]))
		else $error("full scale range high byte not written");

	a_pwr_legal: assert property (@(posedge clk) disable iff (!rstnSync)
		powerModeCode == `CCR_PWR_LOW || powerModeCode == `CCR_PWR_HIGH)
		else $error("power mode holds a reserved code");

	a_delay_sel: assert property (@(posedge clk) disable iff (!rstnSync)
		s_wr(`CCR_ADDR_CLK0) |=> sysrefDelaySelect == $past(wrData[3:0]))
		else $error("delay select did not follow write");

	a_pos_ignore: assert property (@(posedge clk) disable iff (!rstnSync)
		s_posWr |=> $stable(r_q.clk0) && $stable(r_q.fsr) && $stable(r_q.pwr) && r_q.pos == $past(sysrefPosition))
		else $error("write to capture position changed state");

endmodule

// ==== core/ccr_spi_port.sv ====
`timescale 1ns/1ps
`include "ccr_map.svh"

module ccr_spi_port
	import ccr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstnSync,
	// Serial control pins
	input  wire logic        spiSclk,
	input  wire logic        spiCsN,
	input  wire logic        spiSdi,
	output wire logic        spiSdo,
	output wire logic        spiSdoOe,
	// Register side
	output wire logic [14:0] rdAddr,
	input  wire logic [7:0]  rdData,
	output wire logic        wrStb,
	output wire logic [14:0] wrAddr,
	output wire logic [7:0]  wrData
);

	ccr_spi_state_t s_q;
	ccr_spi_state_t s_d;
	logic           sclkRise;
	logic [15:0]    rxNext;

	assign sclkRise = spiSclk & ~s_q.sclkPrev;
	assign rxNext   = {s_q.rxShift[14:0], spiSdi};

	always_comb
	begin
		s_d          = s_q;
		s_d.sclkPrev = spiSclk;
		s_d.wrStb    = 1'b0;
		if (s_q.loadPending)
		begin
			s_d.txShift     = rdData;
			s_d.loadPending = 1'b0;
		end
		if (spiCsN)
		begin
			s_d.phase       = CcrIdle;
			s_d.bitCnt      = 4'h0;
			s_d.loadPending = 1'b0;
		end
		else
		begin
			case (s_q.phase)
				CcrIdle:
				begin
					s_d.phase  = CcrHeader;
					s_d.bitCnt = 4'h0;
				end
				CcrHeader:
				begin
					if (sclkRise)
					begin
						s_d.rxShift = rxNext;
						s_d.bitCnt  = s_q.bitCnt + 4'h1;
						if (s_q.bitCnt == `CCR_HDR_LAST)
						begin
							s_d.isRead      = rxNext[15];
							s_d.addr        = rxNext[14:0];
							s_d.phase       = CcrData;
							s_d.bitCnt      = 4'h0;
							s_d.loadPending = 1'b1;
						end
					end
				end
				CcrData:
				begin
					if (sclkRise)
					begin
						s_d.rxShift = rxNext;
						s_d.txShift = {s_q.txShift[6:0], 1'b0};
						s_d.bitCnt  = s_q.bitCnt + 4'h1;
						if (s_q.bitCnt == `CCR_BYTE_LAST)
						begin
							// Streaming: each further byte goes to the next address
							s_d.wrStb       = ~s_q.isRead;
							s_d.wrAddr      = s_q.addr;
							s_d.wrData      = rxNext[7:0];
							s_d.addr        = s_q.addr + 15'h0001;
							s_d.bitCnt      = 4'h0;
							s_d.loadPending = 1'b1;
						end
					end
				end
				default:
				begin
					s_d.phase = CcrIdle;
				end
			endcase
		end
		s_d.sdoOe = ~spiCsN & (s_d.phase == CcrData) & s_d.isRead;
	end

	always_ff @(posedge clk or negedge rstnSync)
	begin
		if (!rstnSync)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign spiSdo   = s_q.txShift[7];
	assign spiSdoOe = s_q.sdoOe;
	assign rdAddr   = s_q.addr;
	assign wrStb    = s_q.wrStb;
	assign wrAddr   = s_q.wrAddr;
	assign wrData   = s_q.wrData;

endmodule

// ==== include/ccr_map.svh ====
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// Register byte addresses on the serial control port
`define CCR_ADDR_CLK0     15'h0029
`define CCR_ADDR_CLK1     15'h002a
`define CCR_ADDR_CLK2     15'h002b
`define CCR_ADDR_POS0     15'h002c
`define CCR_ADDR_POS1     15'h002d
`define CCR_ADDR_POS2     15'h002e
`define CCR_ADDR_FSR0     15'h0030
`define CCR_ADDR_FSR1     15'h0031
`define CCR_ADDR_PWR1     15'h0037

// Reset values
`define CCR_RST_CLK0      8'h80
`define CCR_RST_CLK1      8'h00
`define CCR_RST_CLK2      8'h10
`define CCR_RST_POS       24'h000000
`define CCR_RST_FSR       16'ha000
`define CCR_RST_PWR1      8'h4b

// Power mode codes
`define CCR_PWR_LOW       8'h46
`define CCR_PWR_HIGH      8'h4b

// Field positions
`define CCR_BIT_MAIN_PECL 2
`define CCR_BIT_SREF_PECL 1
`define CCR_BIT_SREF_INV  0
`define CCR_BIT_ANA_QUIET 2
`define CCR_BIT_CLK_QUIET 0
`define CCR_DLY_MSB       3
`define CCR_DLY_LSB       0

// Serial frame: one direction bit, fifteen address bits, then data bytes
`define CCR_HDR_LAST      4'hf
`define CCR_BYTE_LAST     4'h7

`endif

// ==== include/ccr_pkg.sv ====
package ccr_pkg;

	typedef enum logic [1:0] {CcrIdle, CcrHeader, CcrData} ccr_phase_t;

	typedef struct packed {
		ccr_phase_t  phase;
		logic        sclkPrev;
		logic [3:0]  bitCnt;
		logic [15:0] rxShift;
		logic [7:0]  txShift;
		logic        isRead;
		logic [14:0] addr;
		logic        loadPending;
		logic        sdoOe;
		logic        wrStb;
		logic [14:0] wrAddr;
		logic [7:0]  wrData;
	} ccr_spi_state_t;

	typedef struct packed {
		logic [7:0]  clk0;
		logic [7:0]  clk1;
		logic [7:0]  clk2;
		logic [23:0] pos;
		logic [15:0] fsr;
		logic [7:0]  pwr;
		logic        sysrefOut;
	} ccr_reg_state_t;

endpackage

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`include "ccr_map.svh"

module tb;
	logic        clk;
	logic        rstn;
	logic        sclk;
	logic        csN;
	logic        sdi;
	logic        sysrefIn;
	logic [23:0] sysrefPosition;
	logic        sdo;
	logic        sdoOe;
	logic        aligned;
	logic        mainPecl;
	logic        srefPecl;
	logic        srefInv;
	logic        anaQ;
	logic        clkQ;
	logic [3:0]  dly;
	logic [15:0] fsr;
	logic [7:0]  pwr;
	logic        lowPwr;
	int          errorCnt = 0;
	int          compares = 0;

	ccr_regs #(.POS_WIDTH(24)) DUT (
		.clk(clk), .rstn(rstn), .spiSclk(sclk), .spiCsN(csN), .spiSdi(sdi), .spiSdo(sdo),
		.spiSdoOe(sdoOe), .sysrefIn(sysrefIn), .sysrefPosition(sysrefPosition),
		.sysrefAligned(aligned), .mainClockPeclInputMode(mainPecl), .sysrefPeclInputMode(srefPecl),
		.sysrefPolarityInvert(srefInv), .analogRailQuietingEnable(anaQ),
		.clockRailQuietingEnable(clkQ), .sysrefDelaySelect(dly), .fullScaleRange(fsr),
		.powerModeCode(pwr), .lowPowerMode(lowPwr)
	);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic wrapUp();
		if (errorCnt == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	// One serial bit: low phase, sample data out, then high phase
	task automatic bitx(input logic b, output logic o);
		sclk <= 1'b0;
		sdi <= b;
		@(posedge clk);
		@(negedge clk);
		o = sdo;
		@(posedge clk);
		sclk <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	// Bytes go and come back little endian, one per address
	task automatic frame(input logic rd, input logic [14:0] a, input int n, input logic [23:0] wd,
		output logic [23:0] rv, output logic oe);
		logic [15:0] h;
		logic        o;
		h = {rd, a};
		rv = 24'h0;
		@(posedge clk);
		csN <= 1'b0;
		for (int i = 15; i >= 0; i--)
			bitx(h[i], o);
		for (int k = 0; k < n; k++)
			for (int i = 7; i >= 0; i--)
			begin
				bitx(wd[8*k+i], o);
				rv[8*k+i] = o;
			end
		// Output enable as it stands in the last data bit, before the frame closes
		@(negedge clk);
		oe = sdoOe;
		@(posedge clk);
		csN <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	task automatic wr(input logic [14:0] a, input int n, input logic [23:0] d);
		logic [23:0] rv;
		logic        oe;
		frame(1'b0, a, n, d, rv, oe);
		chk(oe, 1'b0);
	endtask

	task automatic rdchk(input logic [14:0] a, input int n, input logic [23:0] exp);
		logic [23:0] rv;
		logic        oe;
		frame(1'b1, a, n, 24'h0, rv, oe);
		chk(rv, exp);
		chk({oe, sdoOe}, 2'b10);
	endtask

	task automatic t_reset();
		@(negedge clk);
		chk({mainPecl, srefPecl, srefInv, anaQ, clkQ}, 5'h00);
		chk({dly, pwr, lowPwr}, {4'h0, `CCR_RST_PWR1, 1'b0});
		chk(fsr, `CCR_RST_FSR);
		rdchk(`CCR_ADDR_CLK0, 3, {`CCR_RST_CLK2, `CCR_RST_CLK1, `CCR_RST_CLK0});
		rdchk(`CCR_ADDR_FSR0, 2, `CCR_RST_FSR);
		rdchk(`CCR_ADDR_PWR1, 1, `CCR_RST_PWR1);
	endtask

	task automatic t_clk1();
		for (int i = 0; i < 3; i++)
		begin
			wr(`CCR_ADDR_CLK1, 1, 24'h1 << i);
			@(negedge clk);
			chk({mainPecl, srefPecl, srefInv}, 3'h1 << i);
			rdchk(`CCR_ADDR_CLK1, 1, 24'h1 << i);
		end
	endtask

	// Alignment reference follows input, inverted while the polarity bit is set
	task automatic t_sysref();
		for (int p = 1; p >= 0; p--)
		begin
			wr(`CCR_ADDR_CLK1, 1, p);
			for (int v = 0; v < 2; v++)
			begin
				@(posedge clk);
				sysrefIn <= v[0];
				repeat (2) @(posedge clk);
				@(negedge clk);
				chk(aligned, v[0] ^ p[0]);
			end
		end
	endtask

	// Reserved bits are written back at their reset values
	task automatic t_clk2();
		wr(`CCR_ADDR_CLK2, 1, 24'h14);
		@(negedge clk);
		chk({anaQ, clkQ}, 2'b10);
		wr(`CCR_ADDR_CLK2, 1, 24'h11);
		@(negedge clk);
		chk({anaQ, clkQ}, 2'b01);
		rdchk(`CCR_ADDR_CLK2, 1, 24'h11);
	endtask

	task automatic t_pos();
		rdchk(`CCR_ADDR_POS0, 3, 24'h5a3c96);
		wr(`CCR_ADDR_POS0, 3, 24'h000000);
		wr(`CCR_ADDR_POS1, 1, 24'hff);
		rdchk(`CCR_ADDR_POS0, 3, 24'h5a3c96);
		sysrefPosition <= 24'h81e70f;
		rdchk(`CCR_ADDR_POS0, 3, 24'h81e70f);
	endtask

	// Both range ends, written as one two-byte stream
	task automatic t_fsr();
		logic [15:0] v[2] = '{16'h2000, 16'hffff};
		for (int i = 0; i < 2; i++)
		begin
			wr(`CCR_ADDR_FSR0, 2, v[i]);
			@(negedge clk);
			chk(fsr, v[i]);
			rdchk(`CCR_ADDR_FSR0, 2, v[i]);
		end
	endtask

	// Reserved code must not displace the stored mode
	// Companion mode registers, calibration and link enables sit outside this block
	task automatic t_pwr();
		logic [7:0] w[3] = '{`CCR_PWR_LOW, 8'h55, `CCR_PWR_HIGH};
		logic [7:0] e[3] = '{`CCR_PWR_LOW, `CCR_PWR_LOW, `CCR_PWR_HIGH};
		for (int i = 0; i < 3; i++)
		begin
			wr(`CCR_ADDR_PWR1, 1, w[i]);
			@(negedge clk);
			chk({pwr, lowPwr}, {e[i], e[i] == `CCR_PWR_LOW});
			rdchk(`CCR_ADDR_PWR1, 1, e[i]);
		end
	endtask

	// Delay picked from the low nibble of the capture position read first
	task automatic t_dly();
		rdchk(`CCR_ADDR_POS0, 1, 24'h0f);
		wr(`CCR_ADDR_CLK0, 1, 24'h8f);
		@(negedge clk);
		chk(dly, 4'hf);
		wr(`CCR_ADDR_CLK0, 1, 24'h85);
		@(negedge clk);
		chk(dly, 4'h5);
		rdchk(15'h0040, 1, 24'h0);
	endtask

	initial
	begin
		rstn = 1'b0;
		sclk = 1'b0;
		csN = 1'b1;
		sdi = 1'b0;
		sysrefIn = 1'b0;
		sysrefPosition = 24'h5a3c96;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
		t_reset();
		t_clk1();
		t_sysref();
		t_clk2();
		t_pos();
		t_fsr();
		t_pwr();
		t_dly();
		wrapUp();
	end

	initial
	begin
		#800us;
		errorCnt++;
		wrapUp();
	end
endmodule
